// ---- pce_top.sv ----
// module: punctured convolutional encoder with octet feed and mark decode
`timescale 1ns/1ps
// Summary of operation
// RQ1 - rate one half, seven bit constraint
// RQ2 - generators 171 and 133 octal
// RQ3 - invert second branch at rate one half; rate codes 5 to 7 run the rate one half masks without inversion
// RQ4 - first branch symbol before second each bit
// RQ5 - upstream attaches sync marker before encoding
// RQ6 - one punctured rate selectable, same code
// RQ7 - no inversion when punctured
// RQ8 - puncture masks for 2/3, 3/4, 5/6
// RQ9 - rate 7/8 mask, eight symbols per seven
// RQ10 - fixed frames in, gap-free symbols out
// RQ11 - receive path delivers recovered bits upstream
// RQ12 - data randomized before coding unless waived; no randomizer here, octets are encoded as received
// RQ13 - frame check field when no outer code
// RQ14 - soft symbols of three bits for decoder
// RQ15 - mark encoding before the encoder
// RQ16 - mark decoding after the decoder
// RQ17 - fields enter msb first
// RQ18 - reset clears history, commutator, period
// RQ19 - rate changes only from idle
module pce_top
    import pce_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // configuration
    input  wire logic [2:0] rate_sel,
    input  wire logic       diff_en,
    // upstream frame octets
    input  wire logic [7:0] frame_octet,
    input  wire logic       octet_valid,
    output logic            octet_ready,
    output logic            frame_end,
    // symbol stream to the modulator
    output logic            sym_out,
    output logic            sym_valid,
    output logic [2:0]      sym_soft,
    output logic            underrun,
    // decoded bits from the decoder back to the framer
    input  wire logic       dec_bit,
    input  wire logic       dec_valid,
    output logic            lvl_bit,
    output logic            lvl_valid
);

    pce_enc_if eif ();

    pce_enc_core u_core (
        .clk (clk),
        .rst (rst),
        .eif (eif)
    );

    pce_state_type state_reg;
    pce_state_type state_next;
    pce_rate_type  rate_reg;
    pce_rate_type  rate_next;
    logic          diff_reg;
    logic          diff_next;
    logic [2:0]    col_reg;
    logic [2:0]    col_next;
    logic          sym_reg;
    logic          sym_next;
    logic          symv_reg;
    logic          symv_next;
    logic [2:0]    soft_reg;
    logic [2:0]    soft_next;
    logic          under_reg;
    logic          under_next;
    logic          br_reg;
    logic          br_next;
    logic          raw_reg;
    logic          raw_next;
    logic [2:0]    cole_reg;
    logic [2:0]    cole_next;
    logic          adv;
    logic          bit_avail;
    logic          cur_bit;
    logic          c2_out;
    logic          m1;
    logic          m2;
    // serializer state
    logic [7:0]    sh_reg;
    logic [7:0]    sh_next;
    logic [3:0]    bits_reg;
    logic [3:0]    bits_next;
    logic [7:0]    buf_reg;
    logic [7:0]    buf_next;
    logic          bf_reg;
    logic          bf_next;
    logic          ready_reg;
    logic          ready_next;
    logic          mark_reg;
    logic          mark_next;
    logic [15:0]   oct_reg;
    logic [15:0]   oct_next;
    logic          fend_reg;
    logic          fend_next;
    logic          take;
    // receive side state
    logic          prev_dec_reg;
    logic          prev_dec_next;
    logic          lvl_reg;
    logic          lvl_next;
    logic          lvlv_reg;
    logic          lvlv_next;
    // bit presented to the core; marker and check field arrive as ordinary octets
    always_comb begin
        bit_avail = bits_reg != 4'h0;
        cur_bit = diff_reg ? (sh_reg[7] ^ mark_reg) : sh_reg[7]; // RQ12 RQ15 RQ17
        eif.bit_in = cur_bit;
        eif.advance = adv;
        c2_out = (rate_reg == PCE_R12) ? ~eif.c2 : eif.c2; // RQ3 RQ7
        m1 = |(pce_mask1(rate_reg) & (7'h01 << col_reg)); // RQ8 RQ9
        m2 = |(pce_mask2(rate_reg) & (7'h01 << col_reg)); // RQ8 RQ9
    end

    // commutator and puncture sequencing
    always_comb begin
        state_next = state_reg;
        rate_next = rate_reg;
        diff_next = diff_reg;
        col_next = col_reg;
        sym_next = sym_reg;
        symv_next = 1'b0;
        under_next = 1'b0;
        br_next = br_reg;
        raw_next = raw_reg;
        cole_next = col_reg;
        adv = 1'b0;
        unique case (state_reg)
            PCE_ST_IDLE: begin
                // only a fresh period may pick up a new rate
                if (col_reg == PCE_COL_RESET) begin
                    rate_next = pce_rate_type'(rate_sel); // RQ6 RQ19
                    diff_next = diff_en;
                end
                if (bit_avail) begin
                    state_next = PCE_ST_FIRST;
                end
            end
            PCE_ST_FIRST: begin
                if (!bit_avail) begin
                    state_next = PCE_ST_IDLE;
                    under_next = 1'b1;
                end else if (m1) begin
                    sym_next = eif.c1; // RQ4
                    raw_next = eif.c1;
                    br_next = 1'b0;
                    symv_next = 1'b1;
                    if (m2) begin
                        state_next = PCE_ST_SECOND;
                    end else begin
                        adv = 1'b1;
                    end
                end else begin
                    sym_next = c2_out;
                    raw_next = eif.c2;
                    br_next = 1'b1;
                    symv_next = 1'b1;
                    adv = 1'b1;
                end
            end
            PCE_ST_SECOND: begin
                sym_next = c2_out; // RQ4
                raw_next = eif.c2;
                br_next = 1'b1;
                symv_next = 1'b1;
                adv = 1'b1;
                state_next = PCE_ST_FIRST;
            end
        endcase
        if (adv) begin
            col_next = (col_reg == pce_period(rate_reg) - 3'h1) ? PCE_COL_RESET
                                                                 : col_reg + 3'h1;
        end
        // hard symbol mapped to full scale for a soft decoder loopback
        soft_next = sym_next ? PCE_SOFT_ONE : PCE_SOFT_ZERO; // RQ14
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= PCE_ST_IDLE; // RQ18
            rate_reg  <= PCE_R12;
            diff_reg  <= 1'b0;
            col_reg   <= PCE_COL_RESET; // RQ18
            sym_reg   <= 1'b0;
            symv_reg  <= 1'b0;
            soft_reg  <= PCE_SOFT_ZERO;
            under_reg <= 1'b0;
            br_reg    <= 1'b0;
            raw_reg   <= 1'b0;
            cole_reg  <= PCE_COL_RESET;
        end else begin
            state_reg <= state_next;
            rate_reg  <= rate_next;
            diff_reg  <= diff_next;
            col_reg   <= col_next;
            sym_reg   <= sym_next;
            symv_reg  <= symv_next;
            soft_reg  <= soft_next;
            under_reg <= under_next;
            br_reg    <= br_next;
            raw_reg   <= raw_next;
            cole_reg  <= cole_next;
        end
    end

    // octet feed: a holding octet lets the next one wait so bits do not gap while the framer keeps pace
    always_comb begin
        take = octet_valid && ready_reg; // RQ10
        sh_next = sh_reg;
        bits_next = bits_reg;
        buf_next = buf_reg;
        bf_next = bf_reg;
        mark_next = mark_reg;
        oct_next = oct_reg;
        fend_next = 1'b0;
        if (adv) begin
            sh_next = {sh_reg[6:0], 1'b0}; // RQ17
            bits_next = bits_reg - 4'h1;
            mark_next = cur_bit; // RQ15
        end
        if (bits_next == 4'h0 && bf_reg) begin
            sh_next = buf_reg;
            bits_next = PCE_OCTET_BITS;
            bf_next = 1'b0;
        end
        if (take) begin
            buf_next = frame_octet;
            bf_next = 1'b1;
            // frames are a fixed number of octets; marker and check field included
            fend_next = oct_reg == PCE_FRAME_OCTETS - 16'h0001; // RQ5 RQ13
            oct_next = fend_next ? 16'h0000 : oct_reg + 16'h0001;
        end
        ready_next = !bf_next;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sh_reg    <= 8'h00;
            bits_reg  <= 4'h0;
            buf_reg   <= 8'h00;
            bf_reg    <= 1'b0;
            ready_reg <= 1'b0;
            mark_reg  <= 1'b0;
            oct_reg   <= 16'h0000;
            fend_reg  <= 1'b0;
        end else begin
            sh_reg    <= sh_next;
            bits_reg  <= bits_next;
            buf_reg   <= buf_next;
            bf_reg    <= bf_next;
            ready_reg <= ready_next;
            mark_reg  <= mark_next;
            oct_reg   <= oct_next;
            fend_reg  <= fend_next;
        end
    end

    // receive side: mark to level on the decoder output, not on symbols
    always_comb begin
        prev_dec_next = prev_dec_reg;
        lvl_next = lvl_reg;
        lvlv_next = dec_valid; // RQ11
        if (dec_valid) begin
            lvl_next = diff_reg ? (dec_bit ^ prev_dec_reg) : dec_bit; // RQ16
            prev_dec_next = dec_bit;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_dec_reg <= 1'b0;
            lvl_reg      <= 1'b0;
            lvlv_reg     <= 1'b0;
        end else begin
            prev_dec_reg <= prev_dec_next;
            lvl_reg      <= lvl_next;
            lvlv_reg     <= lvlv_next;
        end
    end

    assign octet_ready = ready_reg;
    assign frame_end   = fend_reg;
    assign sym_out     = sym_reg;
    assign sym_valid   = symv_reg;
    assign sym_soft    = soft_reg;
    assign underrun    = under_reg;
    assign lvl_bit     = lvl_reg;
    assign lvl_valid   = lvlv_reg;

    // checks
    sequence s_first_sym;
        symv_reg && !br_reg && rate_reg == PCE_R12;
    endsequence
    sequence s_second_sym;
        symv_reg && br_reg;
    endsequence
    AST_ORDER: assert property (@(posedge clk) disable iff (rst) // RQ4
        s_first_sym |=> s_second_sym)
        else $error("second branch did not follow first at rate one half");
    AST_INVERT: assert property (@(posedge clk) disable iff (rst) // RQ3
        symv_reg && br_reg && rate_reg == PCE_R12 |-> sym_reg == !raw_reg)
        else $error("second branch not inverted at rate one half");
    AST_NO_INVERT: assert property (@(posedge clk) disable iff (rst) // RQ7
        symv_reg && rate_reg != PCE_R12 |-> sym_reg == raw_reg)
        else $error("punctured symbol was inverted");
    AST_MASK: assert property (@(posedge clk) disable iff (rst) // RQ8
        symv_reg |-> (br_reg ? pce_mask2(rate_reg) : pce_mask1(rate_reg)) >> cole_reg != 7'h00
        && ((br_reg ? pce_mask2(rate_reg) : pce_mask1(rate_reg)) & (7'h01 << cole_reg)) != 7'h00)
        else $error("punctured symbol was sent");
    AST_R78_FIRST: assert property (@(posedge clk) disable iff (rst) // RQ9
        symv_reg && !br_reg && rate_reg == PCE_R78
        |-> cole_reg == 3'h0 || cole_reg == 3'h4 || cole_reg == 3'h6)
        else $error("first branch sent at wrong 7/8 column");
    AST_RATE_HOLD: assert property (@(posedge clk) disable iff (rst) // RQ19
        rate_reg != $past(rate_reg) |-> $past(state_reg) == PCE_ST_IDLE
        && $past(col_reg) == PCE_COL_RESET)
        else $error("rate changed outside idle");
    AST_GAPLESS: assert property (@(posedge clk) disable iff (rst) // RQ10
        state_reg == PCE_ST_SECOND |=> symv_reg ##1 (symv_reg || under_reg
        || state_reg == PCE_ST_IDLE))
        else $error("symbol slot lost while bits were held");
    AST_TAKE: assert property (@(posedge clk) disable iff (rst) // RQ10
        take |=> bf_reg && !ready_reg)
        else $error("accepted octet not held");
    AST_RX: assert property (@(posedge clk) disable iff (rst) // RQ11 RQ16
        dec_valid && !diff_reg |=> lvlv_reg && lvl_reg == $past(dec_bit))
        else $error("decoded bit not delivered");
    AST_RESET_STATE: assert property (@(posedge clk) // RQ18
        $past(rst) |-> state_reg == PCE_ST_IDLE && col_reg == PCE_COL_RESET)
        else $error("commutator or period not restarted by reset");
endmodule

// ---- pce_pkg.sv ----
// package: constants, rate codes and puncture tables for the encoder
package pce_pkg;

    // connection vectors, msb is the current bit, lsb the oldest
    localparam logic [6:0] PCE_FIRST_CONNECTION_VECTOR  = 7'h79;
    localparam logic [6:0] PCE_SECOND_CONNECTION_VECTOR = 7'h5B;
    localparam int         PCE_HIST_BITS                = 6;

    // octet framing
    localparam logic [3:0]  PCE_OCTET_BITS   = 4'h8;
    localparam logic [15:0] PCE_FRAME_OCTETS = 16'h0100;

    // soft symbol width offered to a decoder loopback
    localparam int         PCE_SOFT_BITS = 3;
    localparam logic [2:0] PCE_SOFT_ONE  = 3'h7;
    localparam logic [2:0] PCE_SOFT_ZERO = 3'h0;

    // reset values
    localparam logic [2:0] PCE_COL_RESET = 3'h0;

    typedef enum logic [2:0] {
        PCE_R12 = 3'h0,
        PCE_R23 = 3'h1,
        PCE_R34 = 3'h2,
        PCE_R56 = 3'h3,
        PCE_R78 = 3'h4
    } pce_rate_type;

    // gray codes along idle -> first -> second
    typedef enum logic [1:0] {
        PCE_ST_IDLE   = 2'h0,
        PCE_ST_FIRST  = 2'h1,
        PCE_ST_SECOND = 2'h3
    } pce_state_type;

    // puncture masks, bit n is column n, 1 = sent
    localparam logic [6:0] PCE_M1_R12 = 7'h01;
    localparam logic [6:0] PCE_M2_R12 = 7'h01;
    localparam logic [6:0] PCE_M1_R23 = 7'h01;
    localparam logic [6:0] PCE_M2_R23 = 7'h03;
    localparam logic [6:0] PCE_M1_R34 = 7'h05;
    localparam logic [6:0] PCE_M2_R34 = 7'h03;
    localparam logic [6:0] PCE_M1_R56 = 7'h15;
    localparam logic [6:0] PCE_M2_R56 = 7'h0B;
    localparam logic [6:0] PCE_M1_R78 = 7'h51;
    localparam logic [6:0] PCE_M2_R78 = 7'h2F;

    localparam logic [2:0] PCE_P_R12 = 3'h1;
    localparam logic [2:0] PCE_P_R23 = 3'h2;
    localparam logic [2:0] PCE_P_R34 = 3'h3;
    localparam logic [2:0] PCE_P_R56 = 3'h5;
    localparam logic [2:0] PCE_P_R78 = 3'h7;

    function automatic logic [2:0] pce_period(input pce_rate_type r);
        unique case (r)
            PCE_R23: pce_period = PCE_P_R23;
            PCE_R34: pce_period = PCE_P_R34;
            PCE_R56: pce_period = PCE_P_R56;
            PCE_R78: pce_period = PCE_P_R78;
            default: pce_period = PCE_P_R12;
        endcase
    endfunction

    function automatic logic [6:0] pce_mask1(input pce_rate_type r);
        unique case (r)
            PCE_R23: pce_mask1 = PCE_M1_R23;
            PCE_R34: pce_mask1 = PCE_M1_R34;
            PCE_R56: pce_mask1 = PCE_M1_R56;
            PCE_R78: pce_mask1 = PCE_M1_R78;
            default: pce_mask1 = PCE_M1_R12;
        endcase
    endfunction

    function automatic logic [6:0] pce_mask2(input pce_rate_type r);
        unique case (r)
            PCE_R23: pce_mask2 = PCE_M2_R23;
            PCE_R34: pce_mask2 = PCE_M2_R34;
            PCE_R56: pce_mask2 = PCE_M2_R56;
            PCE_R78: pce_mask2 = PCE_M2_R78;
            default: pce_mask2 = PCE_M2_R12;
        endcase
    endfunction

endpackage

// ---- pce_enc_if.sv ----
// interface: bit feed and branch symbols between control and encoder core
`timescale 1ns/1ps
interface pce_enc_if;
    logic bit_in;
    logic advance;
    logic c1;
    logic c2;
    modport core (input bit_in, input advance, output c1, output c2);
    modport user (output bit_in, output advance, input c1, input c2);
endinterface

// ---- pce_enc_core.sv ----
// module: constraint-length 7 history register and the two generator sums
`timescale 1ns/1ps
module pce_enc_core
    import pce_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // bit feed and symbols
    pce_enc_if.core   eif
);

    logic [PCE_HIST_BITS-1:0] hist_reg;
    logic [PCE_HIST_BITS-1:0] hist_next;
    logic [6:0]               window;

    always_comb begin
        window = {eif.bit_in, hist_reg};
        eif.c1 = ^(window & PCE_FIRST_CONNECTION_VECTOR); // RQ2
        eif.c2 = ^(window & PCE_SECOND_CONNECTION_VECTOR); // RQ2
        hist_next = hist_reg;
        if (eif.advance) begin
            hist_next = window[6:1]; // RQ1
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hist_reg <= '0; // RQ18
        end else begin
            hist_reg <= hist_next;
        end
    end

    AST_HIST_CLEAR: assert property (@(posedge clk) $past(rst) |-> hist_reg == '0) // RQ18
        else $error("history not cleared after reset");

    AST_HIST_SHIFT: assert property (@(posedge clk) disable iff (rst) // RQ1
        eif.advance |=> hist_reg == {$past(eif.bit_in), $past(hist_reg[5:1])})
        else $error("history did not take the encoded bit");

endmodule

// ---- pce_framer_model.sv ----
// upstream framer model: offers frame octets to the encoder
`timescale 1ns/1ps
module pce_framer_model #(
    parameter logic [31:0] MARKER   = 32'h5A5A0FF0, // arbitrary marker value
    parameter int          SLOW_GAP = 40
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // pacing
    input  wire logic       slow,
    // octet handshake
    input  wire logic       octet_ready,
    output logic [7:0]      frame_octet,
    output logic            octet_valid
);
    logic [7:0] tx_q [$];

    task automatic load(input logic [7:0] o);
        tx_q.push_back(o);
    endtask

    // marker leads the frame so it is encoded too, msb first
    task automatic load_marker();
        for (int i = 3; i >= 0; i--) begin
            tx_q.push_back(MARKER[i*8 +: 8]);
        end
    endtask

    initial begin
        octet_valid = 1'b0;
        frame_octet = 8'h00;
        forever begin
            @(posedge clk);
            if (rst !== 1'b1 && tx_q.size() > 0) begin
                #1;
                octet_valid = 1'b1;
                frame_octet = tx_q.pop_front();
                do begin
                    @(posedge clk);
                end while (!(octet_ready === 1'b1 || rst === 1'b1));
                #1;
                octet_valid = 1'b0;
                // released bus must not keep showing the old octet
                frame_octet = ~frame_octet;
                if (slow) begin
                    repeat (SLOW_GAP) @(posedge clk);
                end
            end
        end
    end
endmodule

// ---- tb_punctured_conv_encoder.sv ----
// testbench: encoder against a bit-level reference of the code
`timescale 1ns/1ps
module tb_punctured_conv_encoder;
    import pce_pkg::*;
    localparam logic [31:0] MARKER = 32'h5A5A0FF0; // arbitrary marker value
    localparam int          LIMIT  = 30000;
    // masks per rate, bit n is column n
    localparam logic [34:0] M1S  = {7'h51, 7'h15, 7'h05, 7'h01, 7'h01};
    localparam logic [34:0] M2S  = {7'h2F, 7'h0B, 7'h03, 7'h03, 7'h01};
    localparam logic [14:0] PERS = {3'h7, 3'h5, 3'h3, 3'h2, 3'h1};

    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [2:0] rate_sel = 3'h0;
    logic       diff_en = 1'b0;
    logic [7:0] frame_octet;
    logic       octet_valid;
    logic       octet_ready;
    logic       frame_end;
    logic       sym_out;
    logic       sym_valid;
    logic [2:0] sym_soft;
    logic       underrun;
    logic       dec_bit = 1'b0;
    logic       dec_valid = 1'b0;
    logic       lvl_bit;
    logic       lvl_valid;
    logic       slow = 1'b0;
    logic       gap_chk = 1'b0;
    logic       seen = 1'b0;
    logic       fe_exp = 1'b0;
    logic       exp_q [$];
    logic [5:0] r_hist = 6'h00;
    logic       r_prev = 1'b0;
    int         r_col = 0;
    int         n_fail = 0;
    int         checks_done = 0;
    int         cycles = 0;
    int         n_taken = 0;
    int         n_under = 0;
    int         n_fe = 0;

    always #25 clk = ~clk;

    pce_top i_pce_top (
        .clk         (clk),
        .rst         (rst),
        .rate_sel    (rate_sel),
        .diff_en     (diff_en),
        .frame_octet (frame_octet),
        .octet_valid (octet_valid),
        .octet_ready (octet_ready),
        .frame_end   (frame_end),
        .sym_out     (sym_out),
        .sym_valid   (sym_valid),
        .sym_soft    (sym_soft),
        .underrun    (underrun),
        .dec_bit     (dec_bit),
        .dec_valid   (dec_valid),
        .lvl_bit     (lvl_bit),
        .lvl_valid   (lvl_valid)
    );

    pce_framer_model #(.MARKER(MARKER), .SLOW_GAP(40)) i_pce_framer_model (
        .clk         (clk),
        .rst         (rst),
        .slow        (slow),
        .octet_ready (octet_ready),
        .frame_octet (frame_octet),
        .octet_valid (octet_valid)
    );

    task automatic close_out();
        $display("checks %0d, errors %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    // one octet into the reference, msb first, history carried across octets
    task automatic ref_octet(input logic [7:0] o, input logic [2:0] r, input logic diff);
        logic       b;
        logic [6:0] w;
        logic       c1;
        logic       c2;
        logic [2:0] m;
        m = (r > 3'h4) ? 3'h0 : r; // codes past 7/8 use the rate 1/2 masks
        for (int i = 7; i >= 0; i--) begin
            b = o[i];
            if (diff) begin
                b = b ^ r_prev;
                r_prev = b;
            end
            w = {b, r_hist};
            c1 = ^(w & 7'h79);
            c2 = ^(w & 7'h5B);
            if (r == 3'h0) c2 = ~c2;
            if (M1S[m*7 + r_col]) exp_q.push_back(c1);
            if (M2S[m*7 + r_col]) exp_q.push_back(c2);
            r_hist = w[6:1];
            r_col = (r_col + 1) % int'(PERS[m*3 +: 3]);
        end
    endtask

    task automatic do_reset(input logic [2:0] r, input logic diff);
        tick();
        rst = 1'b1;
        rate_sel = r;
        diff_en = diff;
        i_pce_framer_model.tx_q.delete();
        exp_q.delete();
        r_hist = 6'h00;
        r_col = 0;
        r_prev = 1'b0;
        n_under = 0;
        n_fe = 0;
        repeat (5) @(posedge clk);
        #1;
        check(sym_valid === 1'b0 && octet_ready === 1'b0 && underrun === 1'b0,
              "outputs active in reset");
        rst = 1'b0;
    endtask

    task automatic feed(input int n, input logic [7:0] seed, input logic [2:0] r,
                        input logic diff);
        logic [7:0] o;
        for (int k = 0; k < n; k++) begin
            o = seed + 8'(k * 37);
            i_pce_framer_model.load(o);
            ref_octet(o, r, diff);
        end
    endtask

    task automatic drain(input int limit);
        for (int k = 0; k < limit && exp_q.size() > 0; k++) @(posedge clk);
        repeat (4) @(posedge clk);
        check(exp_q.size() == 0, "symbols missing");
    endtask

    always @(posedge clk) begin
        if (rst) begin
            seen = 1'b0;
            n_taken = 0;
            fe_exp = 1'b0;
        end else begin
            if (sym_valid === 1'b1) begin
                seen = 1'b1;
                check(exp_q.size() > 0 && sym_out === exp_q[0], "symbol mismatch");
                if (exp_q.size() > 0) exp_q.delete(0);
                check(sym_soft === (sym_out ? 3'h7 : 3'h0), "soft value");
            end else if (gap_chk && seen && exp_q.size() > 0) begin
                check(1'b0, "gap in symbol stream");
            end
            check(frame_end === fe_exp, "frame end pulse");
            if (frame_end === 1'b1) n_fe++;
            if (underrun === 1'b1) n_under++;
            fe_exp = 1'b0;
            if (octet_valid === 1'b1 && octet_ready === 1'b1) begin
                n_taken++;
                fe_exp = (n_taken % 256 == 0);
            end
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles >= LIMIT) begin
            n_fail++;
            $display("[ERR] %0t run did not finish", $time);
            close_out();
        end
    end

    task automatic sc_rates();
        for (int r = 0; r < 6; r++) begin
            do_reset(3'(r), 1'b0);
            gap_chk = 1'b1;
            feed(7, 8'hC5, 3'(r), 1'b0);
            drain(400);
            check(n_under <= 1, "underrun while fed");
            gap_chk = 1'b0;
        end
    endtask

    task automatic sc_diff();
        do_reset(3'h0, 1'b1);
        feed(4, 8'h3C, 3'h0, 1'b1);
        drain(200);
    endtask

    task automatic sc_rate_change();
        do_reset(3'h1, 1'b0);
        feed(7, 8'h96, 3'h1, 1'b0);
        repeat (10) tick();
        rate_sel = 3'h2;
        drain(400);
        feed(3, 8'h0F, 3'h2, 1'b0);
        drain(200);
    endtask

    task automatic sc_slow();
        do_reset(3'h2, 1'b0);
        slow = 1'b1;
        feed(5, 8'h71, 3'h2, 1'b0);
        drain(800);
        check(n_under > 1, "no underrun while starved");
        slow = 1'b0;
        feed(6, 8'hE1, 3'h2, 1'b0);
        repeat (60) tick();
        do_reset(3'h0, 1'b0);
        feed(2, 8'hFF, 3'h0, 1'b0);
        drain(200);
    endtask

    task automatic sc_frame();
        do_reset(3'h4, 1'b0);
        gap_chk = 1'b1;
        i_pce_framer_model.load_marker();
        for (int k = 3; k >= 0; k--) ref_octet(MARKER[k*8 +: 8], 3'h4, 1'b0);
        feed(252, 8'h2B, 3'h4, 1'b0);
        drain(4000);
        gap_chk = 1'b0;
        check(n_fe == 1, "frame end count");
    endtask

    task automatic sc_decode();
        logic [7:0] pat;
        logic       prev;
        logic       e;
        pat = 8'hB4;
        for (int d = 0; d < 2; d++) begin
            do_reset(3'h0, d[0]);
            prev = 1'b0;
            repeat (3) tick();
            for (int i = 7; i >= 0; i--) begin
                e = d[0] ? (pat[i] ^ prev) : pat[i];
                prev = pat[i];
                dec_bit = pat[i];
                dec_valid = 1'b1;
                tick();
                dec_valid = 1'b0;
                dec_bit = ~dec_bit;
                check(lvl_valid === 1'b1 && lvl_bit === e, "recovered bit");
                tick();
            end
        end
    endtask

    initial begin
        sc_rates();
        sc_diff();
        sc_rate_change();
        sc_slow();
        sc_frame();
        sc_decode();
        close_out();
    end
endmodule
